// ===== core/dma_chan_pkg.sv
// constants, types and helpers shared by the dma channel design files
package dma_chan_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int ADDR_W = 32; // bus and memory address width
  localparam int DATA_W = 32; // bus and memory data width
  localparam int STRB_W = 4; // byte lanes of a data word
  localparam int COUNT_W = 16; // transfer count width

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_POINTER = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 32'h0000_0004;
  localparam logic [ADDR_W-1:0] OFS_ADDR_RELOAD = 32'h0000_0008;
  localparam logic [ADDR_W-1:0] OFS_COUNT_RELOAD = 32'h0000_000C;
  localparam logic [ADDR_W-1:0] OFS_MODE = 32'h0000_0010;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 32'h0000_0014;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 32'h0000_0018;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int MODE_SIZE_LSB = 0; // item size field, two bits
  localparam int CTRL_ENABLE_BIT = 0; // channel_enable_command
  localparam int CTRL_DISABLE_BIT = 1; // channel_disable_command
  localparam int CTRL_ERR_CLEAR_BIT = 2; // clears the error flag
  localparam int STAT_ENABLED_BIT = 0;
  localparam int STAT_RELOAD_ZERO_BIT = 1;
  localparam int STAT_FINISHED_BIT = 2;
  localparam int STAT_ERROR_BIT = 3;
  localparam int STAT_BUSY_BIT = 4;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;

  // ****************************************************************
  // item sizes and address steps
  // ****************************************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [ADDR_W-1:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [ADDR_W-1:0] STEP_HALF = 32'h0000_0002;
  localparam logic [ADDR_W-1:0] STEP_WORD = 32'h0000_0004;

  // ****************************************************************
  // axi4-lite response codes and channel bundles
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // master to slave signals
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_type;

  // slave to master signals
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_type;

  // one memory write request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] size;
  } mem_cmd_type;

  // address step for an item size; the unused code steps a word
  function automatic logic [ADDR_W-1:0] size_step(input logic [1:0] sz);
    if (sz == SIZE_BYTE) begin
      return STEP_BYTE;
    end else if (sz == SIZE_HALF) begin
      return STEP_HALF;
    end else begin
      return STEP_WORD;
    end
  endfunction

  // merge written byte lanes into an old register value
  function automatic logic [DATA_W-1:0] apply_strobe(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ===== core/stream_buffer.sv
// small valid/ready fifo between the peripheral and the memory side
`timescale 1ns/100ps
`default_nettype none
module stream_buffer
  import dma_chan_pkg::*;
#(
  parameter int WIDTH = 32, // word width
  parameter int DEPTH = 2 // number of entries
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // pointer width
  localparam int CW = $clog2(DEPTH + 1); // fill level width

  logic [WIDTH-1:0] mem_q [DEPTH]; // storage
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0] wr_ptr_q, wr_ptr_d; // next slot to fill
  logic [PW-1:0] rd_ptr_q, rd_ptr_d; // oldest slot
  logic [CW-1:0] fill_q, fill_d; // words held
  logic push, pop;

  // handshakes: full refuses, empty shows nothing
  assign in_ready = (fill_q != CW'(DEPTH));
  assign out_valid = (fill_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // next pointers, level and storage
  always_comb begin
    mem_d = mem_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    fill_d = fill_q;
    if (push) begin
      mem_d[wr_ptr_q] = in_data;
      wr_ptr_d = (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
    end
    if (pop) begin
      rd_ptr_d = (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
    end
    if (push && !pop) begin
      fill_d = fill_q + 1'b1;
    end else if (pop && !push) begin
      fill_d = fill_q - 1'b1;
    end
  end

  // register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      fill_q <= fill_d;
    end
    mem_q <= mem_d;
  end

endmodule
`default_nettype wire

// ===== core/axil_slave_port.sv
// axi4-lite slave front end: turns bus beats into register strobes
`timescale 1ns/100ps
`default_nettype none
module axil_slave_port
  import dma_chan_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire axi_req_type bus_req,
  output var axi_rsp_type bus_rsp,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  output logic [STRB_W-1:0] wr_strb,
  input wire logic wr_err,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_err
);

  logic aw_full_q, aw_full_d; // write address held
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic w_full_q, w_full_d; // write data held
  logic [DATA_W-1:0] w_data_q, w_data_d;
  logic [STRB_W-1:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic ar_full_q, ar_full_d; // read address held one cycle
  logic [ADDR_W-1:0] ar_addr_q, ar_addr_d;
  logic rvalid_q, rvalid_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic aw_take, w_take, ar_take, do_write;

  // ****************************************************************
  // channel handshakes
  // ****************************************************************
  assign aw_take = bus_req.awvalid && !aw_full_q;
  assign w_take = bus_req.wvalid && !w_full_q;
  assign ar_take = bus_req.arvalid && !ar_full_q && !rvalid_q;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_en = do_write;
  assign wr_addr = aw_addr_q;
  assign wr_data = w_data_q;
  assign wr_strb = w_strb_q;
  assign rd_addr = ar_addr_q;

  // response bundle
  always_comb begin
    bus_rsp.awready = !aw_full_q;
    bus_rsp.wready = !w_full_q;
    bus_rsp.bvalid = bvalid_q;
    bus_rsp.bresp = bresp_q;
    bus_rsp.arready = !ar_full_q && !rvalid_q;
    bus_rsp.rvalid = rvalid_q;
    bus_rsp.rdata = rdata_q;
    bus_rsp.rresp = rresp_q;
  end

  // next values: address and data in either order, one write at a time
  always_comb begin
    aw_full_d = aw_take ? 1'b1 : (do_write ? 1'b0 : aw_full_q);
    aw_addr_d = aw_take ? bus_req.awaddr : aw_addr_q;
    w_full_d = w_take ? 1'b1 : (do_write ? 1'b0 : w_full_q);
    w_data_d = w_take ? bus_req.wdata : w_data_q;
    w_strb_d = w_take ? bus_req.wstrb : w_strb_q;
    bvalid_d = bvalid_q && !bus_req.bready;
    bresp_d = bresp_q;
    if (do_write) begin
      bvalid_d = 1'b1;
      bresp_d = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    ar_full_d = ar_take;
    ar_addr_d = ar_take ? bus_req.araddr : ar_addr_q;
    rvalid_d = rvalid_q && !bus_req.rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_full_q) begin
      rvalid_d = 1'b1;
      rdata_d = rd_err ? '0 : rd_data;
      rresp_d = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
  end

  // register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      ar_full_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      ar_addr_q <= '0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      ar_full_q <= ar_full_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      ar_addr_q <= ar_addr_d;
    end
  end

endmodule
`default_nettype wire

// ===== core/dma_channel_address_counter.sv
// one dma channel: address pointer, item counter, reload and registers
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module dma_channel_address_counter
  import dma_chan_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire axi_req_type bus_req,
  output var axi_rsp_type bus_rsp,
  input wire logic periph_valid,
  input wire logic [DATA_W-1:0] periph_data,
  output logic periph_ready,
  output logic mem_req,
  output var mem_cmd_type mem_cmd,
  input wire logic mem_ack,
  input wire logic mem_err
);

  typedef enum logic [0:0] {ST_IDLE, ST_WRITE} state_type;

  // ****************************************************************
  // state
  // ****************************************************************
  state_type state_q, state_d; // channel sequencer
  logic [ADDR_W-1:0] pointer_q, pointer_d; // memory_address_pointer
  logic [COUNT_W-1:0] count_q, count_d; // transfer_item_count
  logic [ADDR_W-1:0] areload_q, areload_d; // address_reload_value
  logic [COUNT_W-1:0] creload_q, creload_d; // count_reload_value
  logic [1:0] size_q, size_d; // item size field
  logic enabled_q, enabled_d; // channel running
  logic err_q, err_d; // sticky transfer error
  logic mem_req_q, mem_req_d; // request outstanding
  mem_cmd_type cmd_q, cmd_d; // request payload

  // bus side strobes
  logic wr_en, wr_err, rd_err;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [DATA_W-1:0] wr_data, rd_data, merged;
  logic [STRB_W-1:0] wr_strb;
  logic wr_ptr, wr_cnt, wr_arl, wr_crl, wr_mode, wr_ctrl;
  logic cmd_en, cmd_dis, cmd_clr;

  // buffer side
  logic buf_valid, buf_ready, buf_in_ready;
  logic [DATA_W-1:0] buf_data;
  logic item_done, item_fail, reloading;
  logic [DATA_W-1:0] status_word;

  // ****************************************************************
  // sub blocks
  // ****************************************************************
  axil_slave_port u_bus (
    .clk(clk),
    .rst(rst),
    .bus_req(bus_req),
    .bus_rsp(bus_rsp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  stream_buffer #(.WIDTH(DATA_W), .DEPTH(2)) u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(periph_valid && enabled_q),
    .in_ready(buf_in_ready),
    .in_data(periph_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // peripheral is only accepted while the channel runs
  assign periph_ready = buf_in_ready && enabled_q;
  assign mem_req = mem_req_q;
  assign mem_cmd = cmd_q;

  // ****************************************************************
  // register decode
  // ****************************************************************
  always_comb begin
    wr_ptr = wr_en && (wr_addr == OFS_POINTER);
    wr_cnt = wr_en && (wr_addr == OFS_COUNT);
    wr_arl = wr_en && (wr_addr == OFS_ADDR_RELOAD);
    wr_crl = wr_en && (wr_addr == OFS_COUNT_RELOAD);
    wr_mode = wr_en && (wr_addr == OFS_MODE);
    wr_ctrl = wr_en && (wr_addr == OFS_CONTROL);
    // status is read only: writes accepted and ignored
    wr_err = !(wr_ptr || wr_cnt || wr_arl || wr_crl || wr_mode ||
               wr_ctrl || (wr_addr == OFS_STATUS));
    cmd_en = wr_ctrl && wr_strb[0] && wr_data[CTRL_ENABLE_BIT];
    cmd_dis = wr_ctrl && wr_strb[0] && wr_data[CTRL_DISABLE_BIT];
    cmd_clr = wr_ctrl && wr_strb[0] && wr_data[CTRL_ERR_CLEAR_BIT];
  end

  // status word from live state
  always_comb begin
    status_word = '0;
    status_word[STAT_ENABLED_BIT] = enabled_q;
    status_word[STAT_RELOAD_ZERO_BIT] = (creload_q == COUNT_ZERO);
    status_word[STAT_FINISHED_BIT] = (count_q == COUNT_ZERO) &&
                                     (creload_q == COUNT_ZERO);
    status_word[STAT_ERROR_BIT] = err_q;
    status_word[STAT_BUSY_BIT] = (state_q == ST_WRITE);
  end

  // read mux: every register but control shows its live value
  always_comb begin
    rd_err = 1'b0;
    if (rd_addr == OFS_POINTER) begin
      rd_data = pointer_q;
    end else if (rd_addr == OFS_COUNT) begin
      rd_data = DATA_W'(count_q);
    end else if (rd_addr == OFS_ADDR_RELOAD) begin
      rd_data = areload_q;
    end else if (rd_addr == OFS_COUNT_RELOAD) begin
      rd_data = DATA_W'(creload_q);
    end else if (rd_addr == OFS_MODE) begin
      rd_data = DATA_W'(size_q);
    end else if (rd_addr == OFS_CONTROL) begin
      rd_data = '0; // command bits read as zero
    end else if (rd_addr == OFS_STATUS) begin
      rd_data = status_word;
    end else begin
      rd_data = '0;
      rd_err = 1'b1;
    end
  end

  // ****************************************************************
  // channel sequencer and counters
  // ****************************************************************
  assign item_done = (state_q == ST_WRITE) && mem_ack && !mem_err;
  assign item_fail = (state_q == ST_WRITE) && mem_ack && mem_err;
  assign buf_ready = (state_q == ST_WRITE) && mem_ack;

  always_comb begin
    state_d = state_q;
    pointer_d = pointer_q;
    count_d = count_q;
    areload_d = areload_q;
    creload_d = creload_q;
    size_d = size_q;
    mem_req_d = mem_req_q;
    cmd_d = cmd_q;
    merged = '0;
    reloading = 1'b0;
    case (state_q)
      // issue a write when running, items remain and a word waits
      ST_IDLE: begin
        if (count_q == COUNT_ZERO && creload_q != COUNT_ZERO) begin
          reloading = 1'b1;
        end else if (enabled_q && count_q != COUNT_ZERO &&
                     buf_valid) begin
          mem_req_d = 1'b1;
          cmd_d.addr = pointer_q;
          cmd_d.wdata = buf_data;
          cmd_d.size = size_q;
          state_d = ST_WRITE;
        end
      end
      // hold the request until the memory answers
      ST_WRITE: begin
        if (mem_ack) begin
          mem_req_d = 1'b0;
          state_d = ST_IDLE;
          if (!mem_err) begin
            pointer_d = pointer_q + size_step(cmd_q.size);
            count_d = count_q - COUNT_ONE;
            reloading = (count_q == COUNT_ONE) &&
                        (creload_q != COUNT_ZERO);
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // second buffer follows: reload value consumed once
    if (reloading) begin
      pointer_d = areload_q;
      count_d = creload_q;
      creload_d = COUNT_ZERO;
    end
    // software writes take precedence over the counters
    if (wr_ptr) begin
      pointer_d = apply_strobe(pointer_q, wr_data, wr_strb);
    end
    if (wr_cnt) begin
      merged = apply_strobe(DATA_W'(count_q), wr_data, wr_strb);
      count_d = merged[COUNT_W-1:0];
    end
    if (wr_arl) begin
      areload_d = apply_strobe(areload_q, wr_data, wr_strb);
    end
    if (wr_crl) begin
      merged = apply_strobe(DATA_W'(creload_q), wr_data, wr_strb);
      creload_d = merged[COUNT_W-1:0];
    end
    if (wr_mode && wr_strb[0]) begin
      size_d = wr_data[MODE_SIZE_LSB +: 2];
    end
  end

  // error flag: hardware set beats software clear; enable: any clear beats set
  always_comb begin
    enabled_d = enabled_q;
    if (cmd_en) begin
      enabled_d = 1'b1;
    end
    if (cmd_dis || item_fail) begin
      enabled_d = 1'b0;
    end
    err_d = (err_q && !cmd_clr) || item_fail;
  end

  // register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      pointer_q <= ADDR_RESET;
      count_q <= COUNT_RESET;
      areload_q <= ADDR_RESET;
      creload_q <= COUNT_RESET;
      size_q <= SIZE_BYTE;
      enabled_q <= 1'b0;
      err_q <= 1'b0;
      mem_req_q <= 1'b0;
      cmd_q <= '0;
    end else begin
      state_q <= state_d;
      pointer_q <= pointer_d;
      count_q <= count_d;
      areload_q <= areload_d;
      creload_q <= creload_d;
      size_q <= size_d;
      enabled_q <= enabled_d;
      err_q <= err_d;
      mem_req_q <= mem_req_d;
      cmd_q <= cmd_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  addr_step_a: assert property (
    item_done && !wr_ptr && !reloading |=>
      pointer_q == $past(pointer_q) + size_step($past(cmd_q.size)))
    else $error("pointer did not advance by item size");

  count_dec_a: assert property (
    item_done && !wr_cnt && !reloading |=>
      count_q == $past(count_q) - COUNT_ONE)
    else $error("count did not drop by one");

  reload_load_a: assert property (
    item_done && count_q == COUNT_ONE && creload_q != COUNT_ZERO &&
    !wr_cnt && !wr_ptr && !wr_crl |=>
      count_q == $past(creload_q) && pointer_q == $past(areload_q) &&
      creload_q == COUNT_ZERO)
    else $error("reload values not copied");

  reload_idle_a: assert property (
    state_q == ST_IDLE && count_q == COUNT_ZERO &&
    creload_q != COUNT_ZERO && !wr_cnt |=> count_q != COUNT_ZERO)
    else $error("reload did not fire at zero count");

  finish_stop_a: assert property (
    count_q == COUNT_ZERO && creload_q == COUNT_ZERO &&
    state_q == ST_IDLE |=> !mem_req_q)
    else $error("request issued with nothing left");

  error_flag_a: assert property (
    item_fail |=> err_q && !enabled_q && !mem_req_q)
    else $error("failed access not flagged");

  enable_cmd_a: assert property (
    cmd_en && !cmd_dis && !item_fail |=>
      enabled_q ##1 status_word[STAT_ENABLED_BIT])
    else $error("enable command not taken");

  req_hold_a: assert property (
    mem_req_q && !mem_ack |=> mem_req_q && $stable(cmd_q))
    else $error("request dropped before answer");

  reload_seen_c: cover property (item_done && reloading);
  error_seen_c: cover property (item_fail);
  finish_seen_c: cover property (
    item_done && count_q == COUNT_ONE && creload_q == COUNT_ZERO);
  stall_seen_c: cover property (periph_valid && enabled_q && !periph_ready);

endmodule
`default_nettype wire

// ===== verification/mem_model.sv
// memory bus model that answers the channel's write requests
`timescale 1ns/100ps
`default_nettype none
module mem_model
  import dma_chan_pkg::*;
#(
  parameter int LAT = 2 // idle cycles before each answer
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic mem_req,
  input wire mem_cmd_type mem_cmd,
  input wire logic fail,
  output logic mem_ack,
  output logic mem_err,
  output logic [ADDR_W-1:0] last_addr,
  output var mem_cmd_type last_cmd,
  output int n_ack
);
  int wait_q; // cycles spent on the open request
  // one answer pulse per request, after LAT cycles
  always_ff @(posedge clk) begin
    mem_ack <= 1'h0;
    mem_err <= 1'h0;
    if (rst) begin
      wait_q <= 0;
      n_ack <= 0;
    end else if (mem_req && !mem_ack && wait_q == LAT) begin
      mem_ack <= 1'h1;
      mem_err <= fail;
      last_addr <= mem_cmd.addr;
      last_cmd <= mem_cmd;
      n_ack <= n_ack + 1;
      wait_q <= 0;
    end else if (mem_req && !mem_ack) begin
      wait_q <= wait_q + 1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for one dma channel
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import dma_chan_pkg::*;
;
  logic clk = 1'h0; // system clock
  logic rst; // synchronous reset
  axi_req_type req; // bus master signals
  axi_rsp_type rsp; // bus slave answers
  logic pv, pr; // peripheral valid, ready
  logic [DATA_W-1:0] pd; // peripheral word
  logic mreq, mack, merr, fail; // memory handshake
  mem_cmd_type mcmd; // memory command
  logic [ADDR_W-1:0] maddr; // last answered address
  int nack, cyc = 0, miscompares = 0, n_tests = 0;
  logic [31:0] rdat; // last read data
  logic [1:0] rrsp; // last read response
  logic [1:0] brsp; // last write response
  mem_cmd_type lcmd; // last answered memory command
  logic [1:0] szs [3] = '{SIZE_BYTE, SIZE_HALF, SIZE_WORD};
  logic [31:0] stp [3] = '{STEP_BYTE, STEP_HALF, STEP_WORD};
  always #4 clk = ~clk;
  dma_channel_address_counter dut_u (.clk(clk), .rst(rst),
    .bus_req(req), .bus_rsp(rsp), .periph_valid(pv),
    .periph_data(pd), .periph_ready(pr), .mem_req(mreq),
    .mem_cmd(mcmd), .mem_ack(mack), .mem_err(merr));
  mem_model mem_u (.clk(clk), .rst(rst), .mem_req(mreq),
    .mem_cmd(mcmd), .fail(fail), .mem_ack(mack), .mem_err(merr),
    .last_addr(maddr), .last_cmd(lcmd), .n_ack(nack));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // axi write: hold each channel until taken, bready until bvalid
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw, w, b;
    aw = 1'h1;
    w = 1'h1;
    b = 1'h1;
    req.awvalid <= 1'h1;
    req.awaddr <= a;
    req.wvalid <= 1'h1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'h1;
    while (b) begin
      @(posedge clk);
      if (aw && rsp.awready) aw = 1'h0;
      if (w && rsp.wready) w = 1'h0;
      if (rsp.bvalid) begin
        b = 1'h0;
        brsp = rsp.bresp;
      end
      req.awvalid <= aw;
      req.wvalid <= w;
      req.bready <= b;
    end
    // let an edge pass so the next call never reassigns in this step
    @(posedge clk);
  endtask
  // axi read: hold arvalid until taken, rready until rvalid
  task automatic rd(input logic [31:0] a);
    logic ar;
    ar = 1'h1;
    req.arvalid <= 1'h1;
    req.araddr <= a;
    req.rready <= 1'h1;
    do begin
      @(posedge clk);
      if (ar && rsp.arready) ar = 1'h0;
      req.arvalid <= ar;
    end while (!rsp.rvalid);
    req.rready <= 1'h0;
    rdat = rsp.rdata;
    rrsp = rsp.rresp;
    // let an edge pass so the next call never reassigns in this step
    @(posedge clk);
  endtask
  // offer n words back to back; data line scrambled when released
  task automatic push(input int n, input logic [31:0] d);
    pv <= 1'h1;
    for (int i = 0; i < n; i++) begin
      pd <= d + i;
      do @(posedge clk); while (!pr);
    end
    pv <= 1'h0;
    pd <= ~d;
  endtask
  task automatic acks(input int n);
    while (nack < n) @(posedge clk);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_sim;
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    rst = 1'h1;
    req = '0;
    pv = 1'h0;
    pd = '0;
    fail = 1'h0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(OFS_STATUS);
    chk(rdat, 32'h0000_0006);
    rd(32'h0000_0040);
    chk({30'h0, rrsp}, {30'h0, RESP_SLVERR});
    // one item per size: step, live pointer, count left
    for (int i = 0; i < 3; i++) begin
      wr(OFS_MODE, {30'h0, szs[i]});
      wr(OFS_POINTER, 32'h0000_0100);
      wr(OFS_COUNT, 32'h0000_0002);
      wr(OFS_CONTROL, 32'h0000_0001);
      push(1, 32'hA5A5_0000);
      acks(i + 1);
      chk(maddr, 32'h0000_0100);
      chk(lcmd.wdata, 32'hA5A5_0000);
      chk({30'h0, lcmd.size}, {30'h0, szs[i]});
      rd(OFS_POINTER);
      chk(rdat, 32'h0000_0100 + stp[i]);
      rd(OFS_COUNT);
      chk(rdat, 32'h0000_0001);
      wr(OFS_CONTROL, 32'h0000_0002);
      rd(OFS_STATUS);
      chk(rdat, 32'h0000_0002);
    end
    wr(OFS_COUNT, 32'h0001_FFFF);
    rd(OFS_COUNT);
    chk(rdat, 32'h0000_FFFF);
    // two buffers chained by reload
    wr(OFS_POINTER, 32'h0000_0200);
    wr(OFS_COUNT, 32'h0000_0002);
    wr(OFS_ADDR_RELOAD, 32'h0000_0300);
    wr(OFS_COUNT_RELOAD, 32'h0000_0001);
    wr(OFS_CONTROL, 32'h0000_0001);
    push(2, 32'h1234_0000);
    acks(5);
    rd(OFS_POINTER);
    chk(rdat, 32'h0000_0300);
    rd(OFS_COUNT);
    chk(rdat, 32'h0000_0001);
    push(2, 32'h5678_0000);
    acks(6);
    repeat (20) @(posedge clk);
    chk(nack, 6);
    chk(maddr, 32'h0000_0300);
    chk(lcmd.wdata, 32'h5678_0000);
    rd(OFS_STATUS);
    chk(rdat, 32'h0000_0007);
    // failing write with the left-over word
    fail <= 1'h1;
    wr(OFS_COUNT, 32'h0000_0001);
    acks(7);
    fail <= 1'h0;
    rd(OFS_STATUS);
    chk(rdat, 32'h0000_000A);
    rd(OFS_POINTER);
    chk(rdat, 32'h0000_0304);
    wr(OFS_CONTROL, 32'h0000_0004);
    rd(OFS_STATUS);
    chk(rdat, 32'h0000_0002);
    // unmapped write answers with an error response
    wr(32'h0000_0040, 32'h0000_0000);
    chk({30'h0, brsp}, {30'h0, RESP_SLVERR});
    // idle reload once software zeroes the count
    wr(OFS_COUNT_RELOAD, 32'h0000_0003);
    wr(OFS_COUNT, 32'h0000_0000);
    rd(OFS_COUNT);
    chk(rdat, 32'h0000_0003);
    rd(OFS_POINTER);
    chk(rdat, 32'h0000_0300);
    end_sim;
  end
endmodule
`default_nettype wire
